// ===== common/port_irq_pkg.sv
package port_irq_pkg;
	// bus request carried as one bundle
	typedef struct packed {
		logic        read;
		logic        write;
		logic [15:0] address;
		logic [31:0] writedata;
	} bus_req_t;
	// selected interrupt edge
	typedef enum logic {EDGE_FALL = 1'b0, EDGE_RISE = 1'b1} edge_sel_t;
	// bus slave states, gray from ST_IDLE through ST_ACK to ST_DONE
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACK  = 2'b01,
		ST_DONE = 2'b11
	} bus_state_t;
endpackage

// ===== common/port_irq_regs.svh
`ifndef PORT_IRQ_REGS_SVH
`define PORT_IRQ_REGS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_PORT1_PIN_LEVELS 16'hffd4
`define OFS_PORT5_PIN_LEVELS 16'hffd8
`define OFS_PORT7_PIN_LEVELS 16'hffda
`define OFS_PORT1_FUNC_SEL   16'hffe0
`define OFS_PORT1_DIRECTION  16'hffe4
`define OFS_PORT5_DIRECTION  16'hffe8
`define OFS_IRQ_FLAGS        16'hfff0
`define OFS_IRQ_ENABLE       16'hfff4
// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define BIT_IRQ_FLAG         0
`define BIT_IRQ_PIN          4
`define FUNC_SEL_IRQ         8'h10
`define RST_PORT_DATA        8'h00
`define RST_FUNC_SEL         8'h00
`define RST_DIRECTION        8'h00
`define RST_IRQ_ENABLE       1'h0
`endif

// ===== design/port_irq_pin_setup.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "port_irq_regs.svh"
// Behaviour
// - selected edge on interrupt pin sets flag
// - flag cleared by writing zero after reading one
// - value 0x10 makes port1 bit4 interrupt
// - direction bit zero selects input
// - direction bit one drives data out, except port1 bit4 in irq mode
// - request raised only while enable set
module port_irq_pin_setup
(
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   nrst,
	// avalon-mm slave
	input  wire port_irq_pkg::bus_req_t avs_req,
	output var  logic [31:0]            avs_readdata,
	output var  logic                   avs_waitrequest,
	// port 1 pins
	input  wire logic [7:0]             port1_in,
	output var  logic [7:0]             port1_out,
	output var  logic [7:0]             port1_oe_n,
	// port 5 pins
	input  wire logic [7:0]             port5_in,
	output var  logic [7:0]             port5_out,
	output var  logic [7:0]             port5_oe_n,
	// port 7 outputs
	output var  logic [7:0]             port7_out,
	// interrupt
	input  wire port_irq_pkg::edge_sel_t irq_edge,
	output var  logic                   irq
);
	import port_irq_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] port1_pin_levels;
	logic [7:0] port5_pin_levels;
	logic [7:0] port7_pin_levels;
	logic [7:0] port1_function_select;
	logic [7:0] port1_direction;
	logic [7:0] port5_direction;
	logic       ext_irq_request_flag;
	logic       ext_irq_enable;
	logic       flag_seen_one;
	bus_state_t state;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [7:0] p1_meta;
	logic [7:0] p1_sync;
	logic [7:0] p5_meta;
	logic [7:0] p5_sync;
	logic       pin_prev;

	// two flops on every input pin
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
		begin
			p1_meta  <= 8'h00;
			p1_sync  <= 8'h00;
			p5_meta  <= 8'h00;
			p5_sync  <= 8'h00;
			pin_prev <= 1'b0;
		end
		else
		begin
			p1_meta  <= port1_in;
			p1_sync  <= p1_meta;
			p5_meta  <= port5_in;
			p5_sync  <= p5_meta;
			pin_prev <= p1_sync[`BIT_IRQ_PIN];
		end

	// ----------------------------------------------------------------
	// decode and edge detection
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
		hit = (a[15:2] == o[15:2]);
	endfunction

	wire        irq_mode = (port1_function_select == `FUNC_SEL_IRQ);
	wire        pin_now  = p1_sync[`BIT_IRQ_PIN];
	wire        rise     = pin_now & ~pin_prev;
	wire        fall     = ~pin_now & pin_prev;
	wire        edge_hit = irq_mode &
		((irq_edge == EDGE_RISE) ? rise : fall);
	wire        take     = (state == ST_ACK);
	wire        wr       = take & avs_req.write;
	// a read is decoded as it is first seen, so its data stand with the ack
	wire        rd       = (state == ST_IDLE) & avs_req.read;
	wire [15:0] a        = avs_req.address;
	wire        sel_p1d  = hit(a, `OFS_PORT1_PIN_LEVELS);
	wire        sel_p5d  = hit(a, `OFS_PORT5_PIN_LEVELS);
	// port7 shares a word with port5 data; byte 2 picks it
	wire        sel_p7d  = sel_p5d & (a[1:0] == 2'b10);
	wire        sel_p5x  = sel_p5d & (a[1:0] == 2'b00);
	wire        sel_fs   = hit(a, `OFS_PORT1_FUNC_SEL);
	wire        sel_p1c  = hit(a, `OFS_PORT1_DIRECTION);
	wire        sel_p5c  = hit(a, `OFS_PORT5_DIRECTION);
	wire        sel_fl   = hit(a, `OFS_IRQ_FLAGS);
	wire        sel_en   = hit(a, `OFS_IRQ_ENABLE);
	wire [7:0]  wd       = avs_req.writedata[7:0];
	// clear only when a zero is written after a one was read
	wire        flag_clr = wr & sel_fl & ~wd[`BIT_IRQ_FLAG] &
		flag_seen_one;

	// pin reads mix driven data and sampled inputs per direction
	wire [7:0] p1_view = (port1_direction & port1_pin_levels) |
		(~port1_direction & p1_sync);
	wire [7:0] p5_view = (port5_direction & port5_pin_levels) |
		(~port5_direction & p5_sync);
	wire [7:0] rd_byte =
		sel_p7d ? port7_pin_levels :
		sel_p5x ? p5_view :
		sel_p1d ? p1_view :
		sel_fs  ? port1_function_select :
		sel_p1c ? port1_direction :
		sel_p5c ? port5_direction :
		sel_fl  ? {7'h00, ext_irq_request_flag} :
		sel_en  ? {7'h00, ext_irq_enable} : 8'h00;
	wire [31:0] rd_word = sel_p7d ? {8'h00, rd_byte, 16'h0000} :
		{24'h00_0000, rd_byte};

	// ----------------------------------------------------------------
	// bus handshake: request taken one cycle after it rises
	// ----------------------------------------------------------------
	bus_state_t next_state;
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_IDLE: if (avs_req.read | avs_req.write)
				next_state = ST_ACK;
			ST_ACK:  next_state = ST_DONE;
			ST_DONE: next_state = ST_IDLE;
		endcase
	end

	// state and bus outputs
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
		begin
			state           <= ST_IDLE;
			avs_readdata    <= 32'h0000_0000;
			avs_waitrequest <= 1'b1;
		end
		else
		begin
			state           <= next_state;
			avs_waitrequest <= ~(next_state == ST_ACK);
			avs_readdata    <= rd ? rd_word : 32'h0000_0000;
		end

	// software-written registers
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
		begin
			port1_pin_levels      <= `RST_PORT_DATA;
			port5_pin_levels      <= `RST_PORT_DATA;
			port7_pin_levels      <= `RST_PORT_DATA;
			port1_function_select <= `RST_FUNC_SEL;
			port1_direction       <= `RST_DIRECTION;
			port5_direction       <= `RST_DIRECTION;
			ext_irq_enable        <= `RST_IRQ_ENABLE;
		end
		else if (wr)
		begin
			if (sel_p1d) port1_pin_levels <= wd;
			if (sel_p5x) port5_pin_levels <= wd;
			if (sel_p7d) port7_pin_levels <= avs_req.writedata[23:16];
			if (sel_fs)  port1_function_select <= wd;
			if (sel_p1c) port1_direction <= wd;
			if (sel_p5c) port5_direction <= wd;
			if (sel_en)  ext_irq_enable <= wd[`BIT_IRQ_FLAG];
		end

	// flag: edge sets, set wins over a same-cycle clear
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
		begin
			ext_irq_request_flag <= 1'b0;
			flag_seen_one        <= 1'b0;
		end
		else
		begin
			if (edge_hit)
				ext_irq_request_flag <= 1'b1;
			else if (flag_clr)
				ext_irq_request_flag <= 1'b0;
			if (rd & sel_fl)
				flag_seen_one <= ext_irq_request_flag;
			else if (flag_clr)
				flag_seen_one <= 1'b0;
		end

	// pin drivers and interrupt output
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
		begin
			port1_out  <= 8'h00;
			port1_oe_n <= 8'hff;
			port5_out  <= 8'h00;
			port5_oe_n <= 8'hff;
			port7_out  <= 8'h00;
			irq        <= 1'b0;
		end
		else
		begin
			port1_out  <= port1_pin_levels;
			port1_oe_n <= ~port1_direction |
				(irq_mode ? 8'h10 : 8'h00);
			port5_out  <= port5_pin_levels;
			port5_oe_n <= ~port5_direction;
			port7_out  <= port7_pin_levels;
			irq        <= ext_irq_request_flag & ext_irq_enable;
		end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_edge;
		edge_hit;
	endsequence
	sequence s_flag_up;
		ext_irq_request_flag;
	endsequence

	a_edge_sets_flag: assert property (@(posedge mclk) disable iff (!nrst)
		s_edge |=> s_flag_up)
		else $error("edge did not set flag");
	a_flag_clear_hold: assert property (@(posedge mclk) disable iff (!nrst)
		(flag_clr && !edge_hit) |=> !ext_irq_request_flag)
		else $error("flag not cleared");
	a_flag_no_rise: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(ext_irq_request_flag) |-> $past(edge_hit))
		else $error("flag rose without edge");
	a_irq_mode_pin: assert property (@(posedge mclk) disable iff (!nrst)
		irq_mode |=> port1_oe_n[4])
		else $error("irq pin driven");
	a_no_mode_no_set: assert property (@(posedge mclk) disable iff (!nrst)
		(!irq_mode && !ext_irq_request_flag && !flag_clr) |=>
		!ext_irq_request_flag)
		else $error("flag set outside irq mode");
	a_p1_input_dir: assert property (@(posedge mclk) disable iff (!nrst)
		(port1_direction == 8'h00) |=> (port1_oe_n == 8'hff))
		else $error("port1 not input");
	a_p5_output_dir: assert property (@(posedge mclk) disable iff (!nrst)
		(port5_direction == 8'hff) |=>
		(port5_oe_n == 8'h00 && port5_out == $past(port5_pin_levels)))
		else $error("port5 not driving");
	a_irq_gated: assert property (@(posedge mclk) disable iff (!nrst)
		irq |-> $past(ext_irq_enable) && $past(ext_irq_request_flag))
		else $error("irq without enable");
	a_irq_follows: assert property (@(posedge mclk) disable iff (!nrst)
		(ext_irq_request_flag && ext_irq_enable) |=> irq)
		else $error("irq missing");
	a_clear_needs_read: assert property (@(posedge mclk) disable iff (!nrst)
		(ext_irq_request_flag && !flag_seen_one) |=>
		ext_irq_request_flag)
		else $error("flag cleared without read");
	a_p1_read_input: assert property (@(posedge mclk) disable iff (!nrst)
		(rd && sel_p1d && port1_direction == 8'h00) |=>
		(avs_readdata[7:0] == $past(p1_sync)))
		else $error("port1 read not pin level");
endmodule
`default_nettype wire

// ===== testbench/pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// external pin loads and sources
// ----------------------------------------------------------------
module pin_model
(
	// levels the outside world puts on the pins
	input  wire logic [7:0] ext1,
	input  wire logic [7:0] ext5,
	// block side
	input  wire logic [7:0] port1_out,
	input  wire logic [7:0] port1_oe_n,
	input  wire logic [7:0] port5_out,
	input  wire logic [7:0] port5_oe_n,
	output var  logic [7:0] port1_in,
	output var  logic [7:0] port5_in
);
	// a pin driven by the block shows its own output, else the source
	assign port1_in = (port1_oe_n & ext1) | (~port1_oe_n & port1_out);
	assign port5_in = (port5_oe_n & ext5) | (~port5_oe_n & port5_out);
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "port_irq_regs.svh"
module tb_top;
	import port_irq_pkg::*;
	logic             mclk;
	logic             nrst;
	bus_req_t         req;
	edge_sel_t        irq_edge;
	logic [31:0]      rdata;
	logic             waitreq;
	logic             irq;
	logic [7:0]       ext1;
	logic [7:0]       ext5;
	logic [7:0]       p1_in, p1_out, p1_oe_n, p5_in, p5_out, p5_oe_n, p7_out;
	int               miscompares = 0;
	int               check_count = 0;
	int               cycles = 0;
	int               e;
	logic [31:0]      rdata_q;
	port_irq_pin_setup dut (.mclk(mclk), .nrst(nrst), .avs_req(req),
		.avs_readdata(rdata), .avs_waitrequest(waitreq), .port1_in(p1_in),
		.port1_out(p1_out), .port1_oe_n(p1_oe_n), .port5_in(p5_in),
		.port5_out(p5_out), .port5_oe_n(p5_oe_n), .port7_out(p7_out),
		.irq_edge(irq_edge), .irq(irq));
	pin_model pins (.ext1(ext1), .ext5(ext5), .port1_out(p1_out),
		.port1_oe_n(p1_oe_n), .port5_out(p5_out), .port5_oe_n(p5_oe_n),
		.port1_in(p1_in), .port5_in(p5_in));
	// ----------------------------------------------------------------
	// clock and hang guard
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [15:0] a,
		input logic [31:0] wd);
		@(posedge mclk);
		req <= '{read: ~wr, write: wr, address: a, writedata: wd};
		@(posedge mclk);
		while (waitreq !== 1'b0)
			@(posedge mclk);
		rdata_q = rdata;
		req <= '0;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check(rdata_q, exp);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		nrst = 1'b0;
		req = '0;
		irq_edge = EDGE_FALL;
		ext1 = 8'h5a;
		ext5 = 8'h00;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		check({24'h0000_00, p1_oe_n}, 32'h0000_00ff);
		rd_chk(16'hff00, 32'h0000_0000);
		// all port1 pins are inputs and read the outside levels
		bus(1'b1, `OFS_PORT1_DIRECTION, 32'h0000_0000);
		repeat (4) @(posedge mclk);
		rd_chk(`OFS_PORT1_PIN_LEVELS, 32'h0000_005a);
		check({24'h0000_00, p1_oe_n}, 32'h0000_00ff);
		// all port5 pins are outputs of the data register
		bus(1'b1, `OFS_PORT5_DIRECTION, 32'h0000_00ff);
		bus(1'b1, `OFS_PORT5_PIN_LEVELS, 32'h0000_00a5);
		repeat (2) @(posedge mclk);
		check({p5_oe_n, p5_out}, 16'h00a5);
		rd_chk(`OFS_PORT5_PIN_LEVELS, 32'h0000_00a5);
		bus(1'b1, `OFS_PORT7_PIN_LEVELS, 32'h00c3_0000);
		repeat (2) @(posedge mclk);
		check(p7_out, 8'hc3);
		// switch bit 4 over to the interrupt input
		bus(1'b1, `OFS_PORT1_FUNC_SEL, 32'h0000_0010);
		rd_chk(`OFS_PORT1_FUNC_SEL, 32'h0000_0010);
		check(p1_oe_n[4], 1'b1);
		for (e = 0; e < 2; e++)
		begin
			irq_edge <= edge_sel_t'(e[0]);
			ext1[4] <= ~e[0];
			repeat (6) @(posedge mclk);
			ext1[4] <= e[0];
			repeat (8) @(posedge mclk);
			check(irq, 1'b0);
			bus(1'b1, `OFS_IRQ_FLAGS, 32'h0000_0000);
			rd_chk(`OFS_IRQ_FLAGS, 32'h0000_0001);
			bus(1'b1, `OFS_IRQ_ENABLE, 32'h0000_0001);
			repeat (2) @(posedge mclk);
			check(irq, 1'b1);
			bus(1'b1, `OFS_IRQ_FLAGS, 32'h0000_0000);
			rd_chk(`OFS_IRQ_FLAGS, 32'h0000_0000);
			repeat (2) @(posedge mclk);
			check(irq, 1'b0);
			bus(1'b1, `OFS_IRQ_ENABLE, 32'h0000_0000);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
